// [verilog/sd_logger.sv]
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "logger_cfg.svh"
////////////////////////////////////////////////////////////////////////////
// Contract
// - After reset, prepare an empty log file before any start.
// - Button mode starts a log after a hold over half a second.
// - Button mode ends a running log on a short press.
// - LED off, solid, fast, slow, or pause then error flashes.
// - Logging indicator output is on while card logging is active.
// - Trigger or button mode pulses trigger output at recording start.
// - Modes: disabled, card insertion, button, condition triggered.
// - Triggered mode starts on engine speed, pressure or throttle.
// - Records of 64 or 128 bytes; larger halves the rate (the code samples at the same rate for both sizes).
// - Stream option records 8 kHz mono audio with records.
// - Samples timed, every tooth, or once per engine cycle.
// - Sample interval configurable, never below 3 ms.
// - Files preallocated full size; a full file starts a new one.
// - No free space: overwrite lowest-numbered files first.
// - Error 0 when fine; 1-4 card faults; 5 unsupported card.
// - Filesystem errors 6, 7, 8, 18 and 32.
// - Write errors 17, 29, 30 and 31.
// - Negotiation errors 20, 21-22 and 23-26.
// - SPI clock rate toward the card is configurable.
// - Reset zeroes seconds counter and logs a reset marker.
// - GPS interleave inserts CAN GPS records into the log.
module sd_logger
   import logger_pkg::*;
#(
   parameter int HOLD = `HOLD_CYCLES,
   parameter int SEC = `SEC_CYCLES,
   parameter int MS = `MS_CYCLES,
   parameter int AUDIO = `AUDIO_CYCLES,
   parameter int MAX_FILES = 16
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic card_present_i,
   input wire logic button_i,
   input wire logic [15:0] rpm_i,
   input wire logic [15:0] map_i,
   input wire logic [15:0] tps_i,
   input wire logic tooth_i,
   input wire logic cycle_i,
   input wire logic [11:0] audio_i,
   input wire logic gps_valid_i,
   input wire logic [31:0] gps_data_i,
   input wire logic card_done_i,
   input wire logic [5:0] card_err_i,
   output logic card_init_o,
   output logic card_prep_o,
   output logic spi_tick_o,
   output logic rec_valid_o,
   output logic [1:0] rec_kind_o,
   output logic [31:0] rec_data_o,
   output logic [7:0] rec_bytes_o,
   output logic [15:0] file_index_o,
   output logic led_o,
   output logic log_active_o,
   output logic trig_pulse_o
);
   import logger_pkg::*;

   localparam logic [1:0] KIND_DATA = 2'd0;
   localparam logic [1:0] KIND_AUDIO = 2'd1;
   localparam logic [1:0] KIND_GPS = 2'd2;
   localparam logic [1:0] KIND_MARK = 2'd3;

   typedef struct packed {
      log_state_type st;
      log_mode_type mode;
      trig_src_type src;
      samp_type samp;
      blk_type blk;
      logic gps_en;
      logic [15:0] interval;
      logic [15:0] threshold;
      logic [31:0] file_len;
      logic [7:0] spi_div;
      logic [7:0] spi_cnt;
      logic [5:0] err;
      logic [31:0] sec_cnt;
      logic [31:0] seconds;
      logic [31:0] ms_cnt;
      logic [15:0] iv_cnt;
      logic [31:0] au_cnt;
      logic [31:0] file_used;
      logic [15:0] file_idx;
      logic [15:0] files_free;
      logic mark_pending;
      logic sw_start;
      logic sw_stop;
      logic [31:0] pulse_cnt;
      logic [31:0] rdata;
      logic rec_valid;
      logic [1:0] rec_kind;
      logic [31:0] rec_data;
   } core_type;
   core_type s, next_s;

   logic hold_long;
   logic hold_short;
   logic wr;
   logic ms_tick;
   logic sample_ev;
   logic trig_hit;
   logic stop_ev;
   logic [15:0] trig_val;

   press_timer #(
      .HOLD(HOLD)
   ) u_press (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .button_i(button_i),
      .long_o(hold_long),
      .short_o(hold_short)
   );

   led_flasher u_led (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .state_i(s.st),
      .code_i(s.err),
      .led_o(led_o)
   );

   function automatic logic [15:0] clamp_interval(input logic [15:0] v);
      clamp_interval = (v < 16'(`MIN_INTERVAL_MS)) ? 16'(`MIN_INTERVAL_MS)
                       : v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // APB decode, zero wait states
   assign wr = psel && penable && pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = s.rdata;

   ////////////////////////////////////////////////////////////////////////
   // Event decode
   always_comb begin
      case (s.src)
         SRC_MAP: trig_val = map_i;
         SRC_TPS: trig_val = tps_i;
         default: trig_val = rpm_i;
      endcase
   end
   assign trig_hit = trig_val >= s.threshold;
   assign ms_tick = s.ms_cnt >= 32'(MS - 1);
   always_comb begin
      case (s.samp)
         SAMP_TOOTH: sample_ev = tooth_i;
         SAMP_CYCLE: sample_ev = cycle_i;
         default: sample_ev = ms_tick && (s.iv_cnt >= s.interval - 16'd1);
      endcase
   end
   always_comb begin
      case (s.mode)
         MODE_BUTTON: stop_ev = hold_short || s.sw_stop;
         MODE_TRIGGER: stop_ev = !trig_hit || s.sw_stop;
         MODE_INSERTION: stop_ev = !card_present_i || s.sw_stop;
         default: stop_ev = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Core
   always_comb begin
      next_s = s;
      next_s.rec_valid = 1'b0;
      next_s.sw_start = 1'b0;
      next_s.sw_stop = 1'b0;
      // Seconds since start restart at reset
      next_s.sec_cnt = s.sec_cnt + 32'd1;
      if (s.sec_cnt >= 32'(SEC - 1)) begin
         next_s.sec_cnt = 32'd0;
         next_s.seconds = s.seconds + 32'd1;
      end
      next_s.ms_cnt = ms_tick ? 32'd0 : s.ms_cnt + 32'd1;
      if (ms_tick) begin
         next_s.iv_cnt = (s.iv_cnt >= s.interval - 16'd1) ? 16'd0
                         : s.iv_cnt + 16'd1;
      end
      next_s.spi_cnt = (s.spi_cnt >= s.spi_div) ? 8'd0
                       : s.spi_cnt + 8'd1;
      next_s.au_cnt = (s.au_cnt >= 32'(AUDIO - 1)) ? 32'd0
                      : s.au_cnt + 32'd1;
      if (s.pulse_cnt != 32'd0) begin
         next_s.pulse_cnt = s.pulse_cnt - 32'd1;
      end
      if (psel && !penable) begin
         case (paddr)
            `A_MODE: next_s.rdata = {23'd0, s.gps_en, 2'(s.blk),
                                     2'(s.samp), 2'(s.src), 2'(s.mode)};
            `A_SAMPLE: next_s.rdata = {16'd0, s.interval};
            `A_TRIG: next_s.rdata = {16'd0, s.threshold};
            `A_SPI: next_s.rdata = {24'd0, s.spi_div};
            `A_CMD: next_s.rdata = s.file_len;
            `A_STATUS: next_s.rdata = {7'd0, s.file_idx, 3'(s.st), s.err};
            `A_SECONDS: next_s.rdata = s.seconds;
            `A_CARD: next_s.rdata = {16'd0, s.files_free};
            default: next_s.rdata = 32'd0;
         endcase
      end
      if (wr) begin
         case (paddr)
            `A_MODE: begin
               next_s.mode = log_mode_type'(pwdata[1:0]);
               next_s.src = trig_src_type'(pwdata[3:2]);
               next_s.samp = samp_type'(pwdata[5:4]);
               next_s.blk = blk_type'(pwdata[7:6]);
               next_s.gps_en = pwdata[8];
            end
            `A_SAMPLE: next_s.interval = clamp_interval(pwdata[15:0]);
            `A_TRIG: next_s.threshold = pwdata[15:0];
            `A_SPI: next_s.spi_div = pwdata[7:0];
            `A_CMD: begin
               next_s.file_len = pwdata;
               next_s.sw_start = 1'b0;
            end
            `A_CARD: begin
               next_s.sw_start = pwdata[0];
               next_s.sw_stop = pwdata[1];
               next_s.files_free = pwdata[31:16];
            end
            default: next_s.rdata = s.rdata;
         endcase
      end
      case (s.st)
         ST_OFF: begin
            if (s.mode != MODE_DISABLED && card_present_i) begin
               next_s.st = ST_INIT;
            end
         end
         ST_INIT: begin
            if (card_err_i != `ERR_NONE) begin
               next_s.err = card_err_i;
               next_s.st = ST_ERROR;
            end else if (card_done_i) begin
               next_s.err = `ERR_NONE;
               next_s.st = ST_PREP;
            end
         end
         ST_PREP: begin
            if (card_err_i != `ERR_NONE) begin
               next_s.err = card_err_i;
               next_s.st = ST_ERROR;
            end else if (card_done_i) begin
               next_s.st = ST_READY;
            end
         end
         ST_READY: begin
            if ((s.mode == MODE_INSERTION && card_present_i)
                || (s.mode == MODE_BUTTON && hold_long)
                || (s.mode == MODE_TRIGGER && trig_hit)
                || s.sw_start) begin
               next_s.st = ST_LOG;
               next_s.file_used = 32'd0;
               if (s.mode == MODE_BUTTON || s.mode == MODE_TRIGGER) begin
                  next_s.pulse_cnt = `PULSE_CYCLES;
               end
            end else if (s.mode == MODE_DISABLED) begin
               next_s.st = ST_OFF;
            end
         end
         ST_LOG: begin
            if (card_err_i != `ERR_NONE) begin
               next_s.err = card_err_i;
               next_s.st = ST_ERROR;
            end else if (stop_ev) begin
               // Next empty file prepared for the next log
               next_s.st = ST_PREP;
               next_s.file_idx = s.file_idx + 16'd1;
            end else if (s.mark_pending) begin
               next_s.rec_valid = 1'b1;
               next_s.rec_kind = KIND_MARK;
               next_s.rec_data = s.seconds;
               next_s.mark_pending = 1'b0;
            end else if (sample_ev) begin
               next_s.rec_valid = 1'b1;
               next_s.rec_kind = KIND_DATA;
               next_s.rec_data = {rpm_i, map_i};
               next_s.file_used = s.file_used
                  + ((s.blk == BLK_128) ? 32'(`REC_LARGE)
                     : 32'(`REC_SMALL));
            end else if (s.gps_en && gps_valid_i) begin
               next_s.rec_valid = 1'b1;
               next_s.rec_kind = KIND_GPS;
               next_s.rec_data = gps_data_i;
            end else if (s.blk == BLK_64_STREAM && s.au_cnt == 32'd0) begin
               next_s.rec_valid = 1'b1;
               next_s.rec_kind = KIND_AUDIO;
               next_s.rec_data = {20'd0, audio_i};
            end
            if (!stop_ev && s.file_used >= s.file_len
                && s.file_len != 32'd0) begin
               next_s.file_used = 32'd0;
               if (s.files_free == 16'd0
                   || s.file_idx >= 16'(MAX_FILES - 1)) begin
                  next_s.file_idx = 16'd0;
               end else begin
                  next_s.file_idx = s.file_idx + 16'd1;
                  next_s.files_free = s.files_free - 16'd1;
               end
            end
         end
         ST_ERROR: begin
            if (s.sw_start || !card_present_i) begin
               next_s.st = ST_OFF;
            end
         end
         default: next_s.st = ST_OFF;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s <= '0;
         s.mode <= MODE_INSERTION;
         s.interval <= `INTERVAL_RESET;
         s.spi_div <= `SPI_DIV_RESET;
         s.mark_pending <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign card_init_o = s.st == ST_INIT;
   assign card_prep_o = s.st == ST_PREP;
   assign spi_tick_o = s.spi_cnt == 8'd0;
   assign rec_valid_o = s.rec_valid;
   assign rec_kind_o = s.rec_kind;
   assign rec_data_o = s.rec_data;
   assign rec_bytes_o = (s.blk == BLK_128) ? `REC_LARGE : `REC_SMALL;
   assign file_index_o = s.file_idx;
   assign log_active_o = s.st == ST_LOG;
   assign trig_pulse_o = s.pulse_cnt != 32'd0;
endmodule

// [verilog/logger_cfg.svh]
`ifndef LOGGER_CFG_SVH
`define LOGGER_CFG_SVH
`define A_MODE 12'h000
`define A_SAMPLE 12'h004
`define A_TRIG 12'h008
`define A_SPI 12'h00c
`define A_CMD 12'h010
`define A_STATUS 12'h014
`define A_SECONDS 12'h018
`define A_CARD 12'h01c
`define CLK_HZ 100000000
`define HOLD_MS 500
`define MIN_INTERVAL_MS 3
`define AUDIO_HZ 8000
`define SEC_CYCLES (`CLK_HZ)
`define HOLD_CYCLES (`CLK_HZ / 1000 * `HOLD_MS)
`define MS_CYCLES (`CLK_HZ / 1000)
`define AUDIO_CYCLES (`CLK_HZ / `AUDIO_HZ)
`define FAST_FLASH_CYCLES 32'd5000000
`define SLOW_FLASH_CYCLES 32'd25000000
`define PULSE_CYCLES 32'd1000
`define REC_SMALL 8'd64
`define REC_LARGE 8'd128
`define SPI_DIV_RESET 8'h04
`define INTERVAL_RESET 16'h000a
`define ERR_NONE 6'd0
`define ERR_CLOCK 6'd1
`define ERR_IDLE 6'd2
`define ERR_INIT 6'd3
`define ERR_BLOCK 6'd4
`define ERR_CSD 6'd5
`define ERR_MBR_READ 6'd6
`define ERR_MBR_END 6'd7
`define ERR_NO_PART 6'd8
`define ERR_LOG_WRITE 6'd17
`define ERR_NOT_FAT16 6'd18
`define ERR_HC 6'd20
`define ERR_VCHK_PAT 6'd21
`define ERR_VCHK_REJ 6'd22
`define ERR_OCR1 6'd23
`define ERR_OCR4 6'd26
`define ERR_WRITE 6'd29
`define ERR_DIR_FULL 6'd30
`define ERR_FAT_FULL 6'd31
`define ERR_VBR 6'd32
`endif

// [verilog/logger_pkg.sv]
package logger_pkg;
   typedef enum logic [1:0] {
      MODE_DISABLED = 2'b00,
      MODE_INSERTION = 2'b01,
      MODE_BUTTON = 2'b10,
      MODE_TRIGGER = 2'b11
   } log_mode_type;
   typedef enum logic [1:0] {
      SRC_RPM = 2'b00,
      SRC_MAP = 2'b01,
      SRC_TPS = 2'b10
   } trig_src_type;
   typedef enum logic [1:0] {
      SAMP_TIMED = 2'b00,
      SAMP_TOOTH = 2'b01,
      SAMP_CYCLE = 2'b10
   } samp_type;
   typedef enum logic [1:0] {
      BLK_64 = 2'b00,
      BLK_64_STREAM = 2'b01,
      BLK_128 = 2'b10
   } blk_type;
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_INIT = 3'b001,
      ST_PREP = 3'b010,
      ST_READY = 3'b011,
      ST_LOG = 3'b100,
      ST_ERROR = 3'b101
   } log_state_type;
endpackage

// [verilog/press_timer.sv]
`timescale 1ns/1ps
`include "logger_cfg.svh"
module press_timer #(
   parameter int HOLD = `HOLD_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic button_i,
   output logic long_o,
   output logic short_o
);
   typedef struct packed {
      logic [31:0] count;
      logic fired;
      logic long_ev;
      logic short_ev;
   } press_type;
   press_type s, next_s;

   always_comb begin
      next_s = s;
      next_s.long_ev = 1'b0;
      next_s.short_ev = 1'b0;
      if (button_i) begin
         if (s.count != 32'hffffffff) begin
            next_s.count = s.count + 32'd1;
         end
         // Long hold fires once, while still pressed
         if (!s.fired && s.count >= 32'(HOLD)) begin
            next_s.long_ev = 1'b1;
            next_s.fired = 1'b1;
         end
      end else begin
         if (s.count != 32'd0 && !s.fired) begin
            next_s.short_ev = 1'b1;
         end
         next_s.count = 32'd0;
         next_s.fired = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign long_o = s.long_ev;
   assign short_o = s.short_ev;
endmodule

// [verilog/led_flasher.sv]
`timescale 1ns/1ps
`include "logger_cfg.svh"
module led_flasher
   import logger_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input logger_pkg::log_state_type state_i,
   input wire logic [5:0] code_i,
   output logic led_o
);
   import logger_pkg::*;
   typedef struct packed {
      logic [31:0] timer;
      logic phase;
      logic [6:0] step;
      logic led;
   } flash_type;
   flash_type s, next_s;
   logic [31:0] period;

   always_comb begin
      next_s = s;
      period = (state_i == ST_LOG) ? `SLOW_FLASH_CYCLES : `FAST_FLASH_CYCLES;
      if (s.timer >= period) begin
         next_s.timer = 32'd0;
         next_s.phase = ~s.phase;
         // Error: eight idle steps then code_i + 1 blinks
         if (s.phase) begin
            next_s.step = (s.step >= 7'({code_i, 1'b0} + 7'd8)) ? 7'd0
                          : s.step + 7'd1;
         end
      end else begin
         next_s.timer = s.timer + 32'd1;
      end
      case (state_i)
         ST_OFF: next_s.led = 1'b0;
         ST_READY: next_s.led = 1'b1;
         ST_INIT, ST_PREP: next_s.led = s.phase;
         ST_LOG: next_s.led = s.phase;
         ST_ERROR: next_s.led = (s.step >= 7'd8) && !s.step[0];
         default: next_s.led = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign led_o = s.led;
endmodule

// [tb/sd_logger_checker.sv]
`timescale 1ns/1ps
module sd_logger_checker (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic card_init_o,
   input wire logic card_prep_o,
   input wire logic rec_valid_o,
   input wire logic [1:0] rec_kind_o,
   input wire logic [7:0] rec_bytes_o,
   input wire logic log_active_o,
   input wire logic trig_pulse_o
);
   int unsigned high_cnt;
   logic seen_rec;
   ////////////////////////////////////////////////////////////////////////
   // Pulse length and first-record tracking
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         high_cnt <= 0;
         seen_rec <= 1'b0;
      end else begin
         high_cnt <= trig_pulse_o ? high_cnt + 1 : 0;
         if (rec_valid_o) begin
            seen_rec <= 1'b1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence pulse_starts;
      $rose(trig_pulse_o);
   endsequence
   sequence pulse_ends;
      $fell(trig_pulse_o);
   endsequence
   a_pulse_width: assert property (pulse_ends |-> high_cnt == 1000)
      else $error("trigger pulse width wrong");
   a_pulse_holds: assert property (pulse_starts |-> trig_pulse_o[*8])
      else $error("trigger pulse too short");
   a_pulse_at_start: assert property (pulse_starts |-> ##[0:2] log_active_o)
      else $error("trigger pulse without log start");
   a_prep_exclusive: assert property (!(card_init_o && card_prep_o))
      else $error("init and prepare together");
   a_prep_before_log: assert property (card_prep_o |-> !log_active_o)
      else $error("logging while preparing file");
   a_active_no_init: assert property (log_active_o |-> !card_init_o)
      else $error("logging while card initialises");
   a_first_mark: assert property (rec_valid_o && !seen_rec |-> rec_kind_o == 2'd3)
      else $error("first record is not a reset mark");
   a_data_in_log: assert property (rec_valid_o && rec_kind_o == 2'd0
      |-> log_active_o || $past(log_active_o))
      else $error("data record outside a log");
   a_record_size: assert property (rec_bytes_o == 8'd64 || rec_bytes_o == 8'd128)
      else $error("record size invalid");
   a_read_hold: assert property (!psel || penable |=> $stable(prdata))
      else $error("read data moved outside setup");
   a_ready_high: assert property (pready)
      else $error("pready low");
endmodule
bind sd_logger sd_logger_checker chk (.*);

// [tb/card_model.sv]
`timescale 1ns/1ps
module card_model (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic init_i,
   input wire logic prep_i,
   input wire logic [5:0] code_i,
   input wire logic [3:0] dly_i,
   output logic done_o,
   output logic [5:0] err_o
);
   logic [1:0] step;
   logic [4:0] cnt;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         step <= 2'b00;
         cnt <= 5'h00;
         done_o <= 1'b0;
         err_o <= 6'h00;
      end else begin
         step <= {init_i, prep_i};
         done_o <= 1'b0;
         if ({init_i, prep_i} != step || !(init_i || prep_i)) begin
            cnt <= 5'h00;
         end else if (cnt != 5'h1f) begin
            cnt <= cnt + 5'h01;
         end
         // Failing card reports its code as a level while init runs
         err_o <= (init_i && cnt > {1'b0, dly_i}) ? code_i : 6'h00;
         if (cnt == {1'b0, dly_i} + 5'h02 && !(init_i && code_i != 6'h00)) begin
            done_o <= 1'b1;
         end
      end
   end
endmodule

// [tb/test_sd_logger.sv]
`timescale 1ns/1ps
`include "logger_cfg.svh"
module test_sd_logger;
   import logger_pkg::*;
   logic clk_i, rst_b_i, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr, audio_i;
   logic [31:0] pwdata, prdata, rd, gps_data_i, rec_data_o;
   logic card_present_i, button_i, tooth_i, cycle_i, gps_valid_i;
   logic [15:0] rpm_i, map_i, tps_i, file_index_o;
   logic card_done_i, card_init_o, card_prep_o, spi_tick_o, rec_valid_o;
   logic [5:0] card_err_i, err_code;
   logic [1:0] rec_kind_o;
   logic [7:0] rec_bytes_o;
   logic led_o, log_active_o, trig_pulse_o;
   logic [3:0] dly;
   int bad_count, checks_done, n;
   localparam logic [31:0] ROWS [6][3] = '{'{32'h0, 32'h1a5, 32'h1a5},
      '{32'h4, 32'h3, 32'h3}, '{32'h4, 32'h1, 32'h3},
      '{32'h8, 32'h1234, 32'h1234},
      '{32'hc, 32'h7, 32'h7}, '{32'h20, 32'hffff, 32'h0}};
   localparam logic [5:0] CODES [4] = '{6'd1, 6'd5, 6'd18, 6'd32};
   sd_logger #(.HOLD(20), .SEC(100), .MS(10), .AUDIO(5)) dut (.*);
   card_model partner (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .init_i(card_init_o), .prep_i(card_prep_o), .code_i(err_code),
      .dly_i(dly), .done_o(card_done_i), .err_o(card_err_i));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         bad_count++;
      end
   endtask
   task automatic tick(int c);
      repeat (c) @(posedge clk_i);
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      int k;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready !== 1'b1 && k < 50);
      check("pready", 1, pready);
      if (pready !== 1'b1) wrap_up();
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(string nm, logic [11:0] a, logic [31:0] exp);
      apb(1'b0, a, 0);
      check(nm, exp, rd);
   endtask
   function automatic logic pick(int sel);
      case (sel)
         0: pick = spi_tick_o;
         1: pick = card_init_o;
         2: pick = card_prep_o;
         3: pick = log_active_o;
         default: pick = trig_pulse_o;
      endcase
   endfunction
   task automatic wait_sig(int sel, logic v, int lim);
      int k;
      k = 0;
      while (pick(sel) !== v && k < lim) begin
         @(posedge clk_i);
         k++;
      end
      check("wait", v, pick(sel));
      if (pick(sel) !== v) wrap_up();
   endtask
   task automatic wait_state(logic [2:0] st);
      int k;
      k = 0;
      do begin
         apb(1'b0, `A_STATUS, 0);
         k++;
      end while (rd[8:6] !== st && k < 100);
      check("state", st, rd[8:6]);
      if (rd[8:6] !== st) wrap_up();
   endtask
   task automatic wait_rec(logic [1:0] kd, int lim);
      int k;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (!(rec_valid_o === 1'b1 && rec_kind_o === kd) && k < lim);
      check("record", kd, (rec_valid_o === 1'b1) ? rec_kind_o : 2'bxx);
      if (rec_valid_o !== 1'b1) wrap_up();
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {card_present_i, button_i, tooth_i, cycle_i, gps_valid_i} = '0;
      gps_data_i = 32'h0;
      rpm_i = 16'h0bb8;
      map_i = 16'h0064;
      tps_i = 16'h0032;
      audio_i = 12'h5a5;
      err_code = 6'h00;
      dly = 4'h0;
      rst_b_i = 1'b0;
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd_chk("mode", `A_MODE, 32'h1);
      rd_chk("interval", `A_SAMPLE, 32'ha);
      rd_chk("spi_div", `A_SPI, 32'h4);
      rd_chk("seconds", `A_SECONDS, 32'h0);
      $display("reset test done");
      foreach (ROWS[i]) begin
         apb(1'b1, ROWS[i][0][11:0], ROWS[i][1]);
         rd_chk("register", ROWS[i][0][11:0], ROWS[i][2]);
      end
      apb(1'b1, `A_SPI, 32'h2);
      wait_sig(0, 1'b1, 50);
      tick(1);
      n = 1;
      while (spi_tick_o !== 1'b1 && n < 50) begin
         tick(1);
         n++;
      end
      check("tick_gap", 3, n);
      $display("register test done");
      apb(1'b1, `A_MODE, 32'h101);
      card_present_i <= 1'b1;
      wait_sig(1, 1'b1, 50);
      wait_sig(2, 1'b1, 200);
      wait_sig(3, 1'b1, 200);
      check("bytes", 64, rec_bytes_o);
      wait_rec(2'd0, 200);
      gps_data_i <= 32'hcafe0001;
      gps_valid_i <= 1'b1;
      tick(1);
      gps_valid_i <= 1'b0;
      wait_rec(2'd2, 300);
      check("gps_data", 32'hcafe0001, rec_data_o);
      apb(1'b1, `A_MODE, 32'h181);
      wait_rec(2'd0, 300);
      tick(2);
      check("bytes", 128, rec_bytes_o);
      $display("insertion test done");
      foreach (CODES[i]) begin
         card_present_i <= 1'b0;
         err_code <= CODES[i];
         dly <= 4'h9;
         apb(1'b1, `A_MODE, 32'h0);
         wait_state(3'd0);
         apb(1'b1, `A_MODE, 32'h181);
         card_present_i <= 1'b1;
         wait_state(3'd5);
         check("err", CODES[i], rd[5:0]);
      end
      card_present_i <= 1'b0;
      err_code <= 6'h00;
      dly <= 4'h0;
      tick(5);
      apb(1'b0, `A_STATUS, 0);
      check("err_held", {3'd0, CODES[3]}, rd[8:0]);
      check("led_off", 0, led_o);
      $display("error test done");
      apb(1'b1, `A_MODE, 32'h2);
      card_present_i <= 1'b1;
      wait_state(3'd3);
      check("err_clear", 0, rd[5:0]);
      check("led_on", 1, led_o);
      button_i <= 1'b1;
      tick(15);
      button_i <= 1'b0;
      tick(10);
      check("log", 0, log_active_o);
      button_i <= 1'b1;
      tick(30);
      button_i <= 1'b0;
      wait_sig(3, 1'b1, 100);
      check("trig", 1, trig_pulse_o);
      tick(20);
      button_i <= 1'b1;
      tick(3);
      button_i <= 1'b0;
      wait_sig(3, 1'b0, 100);
      check("file_index", 2, file_index_o);
      $display("button test done");
      wait_sig(4, 1'b0, 1100);
      apb(1'b1, `A_MODE, 32'h47);
      map_i <= 16'h1234;
      wait_sig(3, 1'b1, 100);
      check("trig", 1, trig_pulse_o);
      wait_rec(2'd1, 50);
      check("audio", 32'h5a5, rec_data_o);
      map_i <= 16'h0064;
      wait_sig(3, 1'b0, 50);
      $display("trigger test done");
      rst_b_i <= 1'b0;
      tick(2);
      rst_b_i <= 1'b1;
      rd_chk("seconds", `A_SECONDS, 32'h0);
      rd_chk("mode", `A_MODE, 32'h1);
      $display("second reset test done");
      wrap_up();
   end
endmodule
